// file: cal_ctrl_status_regs.v
// The AXI4-Lite slave port was chosen for this implementation.
`include "cal_regs_defs.vh"

module cal_ctrl_status_regs (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire awvalid,
    output wire awready,
    input wire [`ADDR_W-1:0] awaddr,
    input wire [2:0] awprot,
    // AXI4-Lite write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // AXI4-Lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // AXI4-Lite read address
    input wire arvalid,
    output wire arready,
    input wire [`ADDR_W-1:0] araddr,
    input wire [2:0] arprot,
    // AXI4-Lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // Device pins
    input wire cal_trigger_pin,
    input wire alarm_flag,
    output reg cal_indicator_pin,
    // Calibration datapath controls
    output reg cal_trigger,
    output wire core_wake,
    output wire [2:0] offset_avg_sel,
    output wire [2:0] linearity_avg_sel,
    output wire [2:0] lp_sleep_delay_sel,
    output wire [1:0] lp_wake_delay_sel
);

// Register storage
reg [7:0] run_control;
reg [7:0] calibration_averaging;
reg [7:0] calibration_pin_setup;
reg [7:0] calibration_sw_trigger;
reg [7:0] low_power_recal_timing;

// Write channel holding state
reg aw_held;
reg w_held;
reg [7:0] aw_idx;
reg aw_top_bad;
reg [7:0] w_byte;
reg w_lane;

// Synchronised pins and engine status
wire trigger_sync;
wire alarm_sync;
wire [2:0] state_code;
wire foreground_complete;
wire background_halted;

// Field views
wire cal_enable;
wire foreground_run_enable;
wire background_enable;
wire lp_trigger_mode;
wire hw_trigger_select;
wire sw_trigger_bit;
wire [1:0] indicator_sel;

// Read decode
wire [7:0] rd_idx;
reg [7:0] rd_value;
wire do_write;

// Only these indices answer OKAY; anything else gets SLVERR
function is_mapped;
    input [7:0] idx;
    begin
        case (idx)
            `IDX_RUN_CONTROL: is_mapped = 1'b1;
            `IDX_CAL_AVERAGING: is_mapped = 1'b1;
            `IDX_CAL_STATE: is_mapped = 1'b1;
            `IDX_PIN_SETUP: is_mapped = 1'b1;
            `IDX_SW_TRIGGER: is_mapped = 1'b1;
            `IDX_LP_TIMING: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    end
endfunction

assign cal_enable = run_control[`RUN_CAL_EN_BIT];
assign foreground_run_enable = run_control[`RUN_FG_BIT];
assign background_enable = run_control[`RUN_BG_BIT];
assign lp_trigger_mode = background_enable &&
    low_power_recal_timing[`LP_EN_BIT] &&
    low_power_recal_timing[`LP_TRIG_BIT];
assign hw_trigger_select = calibration_pin_setup[`TRIG_SEL_BIT];
assign sw_trigger_bit = calibration_sw_trigger[`SW_TRIG_BIT];
assign indicator_sel = calibration_pin_setup[`IND_SEL_MSB:`IND_SEL_LSB];

assign offset_avg_sel =
    calibration_averaging[`OFS_AVG_MSB:`OFS_AVG_LSB];
assign linearity_avg_sel =
    calibration_averaging[`LIN_AVG_MSB:`LIN_AVG_LSB];
assign lp_sleep_delay_sel =
    low_power_recal_timing[`LP_SLEEP_MSB:`LP_SLEEP_LSB];
assign lp_wake_delay_sel =
    low_power_recal_timing[`LP_WAKE_MSB:`LP_WAKE_LSB];

// Pins come from outside the clock domain
bit_sync #(
    .RESET_LEVEL(1'b1)
) trigger_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(cal_trigger_pin),
    .sync_out(trigger_sync)
);

bit_sync #(
    .RESET_LEVEL(1'b0)
) alarm_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(alarm_flag),
    .sync_out(alarm_sync)
);

cal_sequencer sequencer_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .cal_enable(cal_enable),
    .foreground_run_enable(foreground_run_enable),
    .background_enable(background_enable),
    .lp_trigger_mode(lp_trigger_mode),
    .cal_trigger(cal_trigger),
    .offset_avg_sel(offset_avg_sel),
    .linearity_avg_sel(linearity_avg_sel),
    .state_code(state_code),
    .foreground_complete(foreground_complete),
    .background_halted(background_halted),
    .core_wake(core_wake)
);

// Write address and data are taken independently, one write in flight
assign awready = !aw_held && !bvalid;
assign wready = !w_held && !bvalid;
assign do_write = aw_held && w_held && !bvalid;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        aw_idx <= `IDX_RUN_CONTROL;
        aw_top_bad <= 1'b0;
    end else if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_idx <= awaddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
        aw_top_bad <= |awaddr[`ADDR_TOP_MSB:`ADDR_TOP_LSB];
    end else if (do_write) begin
        aw_held <= 1'b0;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        w_held <= 1'b0;
        w_byte <= `RST_PIN_SETUP;
        w_lane <= 1'b0;
    end else if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
    end else if (do_write) begin
        w_held <= 1'b0;
    end
end

// Register commit; reserved bits are masked so they always read zero
always @(posedge aclk) begin
    if (!aresetn) begin
        run_control <= `RST_RUN_CONTROL;
        calibration_averaging <= `RST_CAL_AVERAGING;
        calibration_pin_setup <= `RST_PIN_SETUP;
        calibration_sw_trigger <= `RST_SW_TRIGGER;
        low_power_recal_timing <= `RST_LP_TIMING;
    end else if (do_write && w_lane && !aw_top_bad) begin
        case (aw_idx)
            `IDX_RUN_CONTROL: begin
                run_control <= w_byte & `MASK_RUN_CONTROL;
            end
            `IDX_CAL_AVERAGING: begin
                calibration_averaging <=
                    w_byte & `MASK_CAL_AVERAGING;
            end
            `IDX_PIN_SETUP: begin
                calibration_pin_setup <=
                    w_byte & `MASK_PIN_SETUP;
            end
            `IDX_SW_TRIGGER: begin
                calibration_sw_trigger <=
                    w_byte & `MASK_SW_TRIGGER;
            end
            `IDX_LP_TIMING: begin
                low_power_recal_timing <=
                    w_byte & `MASK_LP_TIMING;
            end
            default: begin
                // Status index falls here: accepted, nothing changes
                run_control <= run_control;
            end
        endcase
    end
end

// Write response
always @(posedge aclk) begin
    if (!aresetn) begin
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
    end else if (do_write) begin
        bvalid <= 1'b1;
        if (is_mapped(aw_idx) && !aw_top_bad) begin
            bresp <= `RESP_OKAY;
        end else begin
            bresp <= `RESP_SLVERR;
        end
    end else if (bready) begin
        bvalid <= 1'b0;
    end
end

// Read path: one cycle from address to data
assign arready = !rvalid;
assign rd_idx = araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

always @* begin
    rd_value = `RST_PIN_SETUP;
    case (rd_idx)
        `IDX_RUN_CONTROL: rd_value = run_control;
        `IDX_CAL_AVERAGING: rd_value = calibration_averaging;
        `IDX_CAL_STATE: begin
            rd_value[`STAT_CODE_MSB:`STAT_CODE_LSB] = state_code;
            rd_value[`STAT_HALT_BIT] = background_halted;
            rd_value[`STAT_FG_BIT] = foreground_complete;
        end
        `IDX_PIN_SETUP: rd_value = calibration_pin_setup;
        `IDX_SW_TRIGGER: rd_value = calibration_sw_trigger;
        `IDX_LP_TIMING: rd_value = low_power_recal_timing;
        default: rd_value = `RST_PIN_SETUP;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid <= 1'b0;
        rdata <= {`RDATA_PAD, `RST_PIN_SETUP};
        rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
        rvalid <= 1'b1;
        if (is_mapped(rd_idx) && !(|araddr[`ADDR_TOP_MSB:`ADDR_TOP_LSB]))
        begin
            rdata <= {`RDATA_PAD, rd_value};
            rresp <= `RESP_OKAY;
        end else begin
            rdata <= {`RDATA_PAD, `RST_PIN_SETUP};
            rresp <= `RESP_SLVERR;
        end
    end else if (rready) begin
        rvalid <= 1'b0;
    end
end

// Trigger source; the unused source is not looked at at all
always @(posedge aclk) begin
    if (!aresetn) begin
        cal_trigger <= 1'b1;
    end else if (hw_trigger_select) begin
        cal_trigger <= trigger_sync;
    end else begin
        cal_trigger <= sw_trigger_bit;
    end
end

// Indicator pin is registered so it never glitches on select changes
always @(posedge aclk) begin
    if (!aresetn) begin
        cal_indicator_pin <= 1'b0;
    end else begin
        case (indicator_sel)
            `IND_FG: cal_indicator_pin <= foreground_complete;
            `IND_HALT: cal_indicator_pin <= background_halted;
            `IND_ALARM: cal_indicator_pin <= alarm_sync;
            `IND_LOW: cal_indicator_pin <= 1'b0;
            default: cal_indicator_pin <= 1'b0;
        endcase
    end
end

endmodule // cal_ctrl_status_regs

// file: cal_regs_defs.vh
`ifndef CAL_REGS_DEFS_VH
`define CAL_REGS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_RUN_CONTROL 8'h62
`define IDX_CAL_AVERAGING 8'h68
`define IDX_CAL_STATE 8'h6a
`define IDX_PIN_SETUP 8'h6b
`define IDX_SW_TRIGGER 8'h6c
`define IDX_LP_TIMING 8'h6e

// AXI address split
`define ADDR_W 12
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2
`define ADDR_TOP_MSB 11
`define ADDR_TOP_LSB 10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RDATA_PAD 24'h00_0000

// Reset values
`define RST_RUN_CONTROL 8'h03
`define RST_CAL_AVERAGING 8'h61
`define RST_PIN_SETUP 8'h00
`define RST_SW_TRIGGER 8'h01
`define RST_LP_TIMING 8'h88

// Writable bits; reserved positions stay zero
`define MASK_RUN_CONTROL 8'h07
`define MASK_CAL_AVERAGING 8'h77
`define MASK_PIN_SETUP 8'h07
`define MASK_SW_TRIGGER 8'h01
`define MASK_LP_TIMING 8'hfb

// Field positions
`define RUN_CAL_EN_BIT 0
`define RUN_FG_BIT 1
`define RUN_BG_BIT 2
`define OFS_AVG_MSB 6
`define OFS_AVG_LSB 4
`define LIN_AVG_MSB 2
`define LIN_AVG_LSB 0
`define STAT_FG_BIT 0
`define STAT_HALT_BIT 1
`define STAT_CODE_MSB 4
`define STAT_CODE_LSB 2
`define IND_SEL_MSB 2
`define IND_SEL_LSB 1
`define TRIG_SEL_BIT 0
`define SW_TRIG_BIT 0
`define LP_EN_BIT 0
`define LP_TRIG_BIT 1
`define LP_WAKE_MSB 4
`define LP_WAKE_LSB 3
`define LP_SLEEP_MSB 7
`define LP_SLEEP_LSB 5

// Indicator source codes
`define IND_FG 2'h0
`define IND_HALT 2'h1
`define IND_ALARM 2'h2
`define IND_LOW 2'h3

// Calibration state codes
`define CS_IDLE 3'h0
`define CS_RESET 3'h1
`define CS_FG 3'h2
`define CS_BG_RUN 3'h3
`define CS_BG_HALT 3'h4
`define CS_DONE 3'h5

// Averaging timing: base cycles shifted left by the depth select
`define AVG_BASE_CYCLES 12'h010
`define COUNT_ZERO 12'h000
`define COUNT_LAST 12'h001

`endif

// file: bit_sync.v
module bit_sync #(
    parameter [0:0] RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output reg sync_out
);

reg stage_one;

always @(posedge aclk) begin
    if (!aresetn) begin
        stage_one <= RESET_LEVEL;
        sync_out <= RESET_LEVEL;
    end else begin
        stage_one <= async_in;
        sync_out <= stage_one;
    end
end

endmodule // bit_sync

// file: cal_sequencer.v
`include "cal_regs_defs.vh"

module cal_sequencer (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Controls
    input wire cal_enable,
    input wire foreground_run_enable,
    input wire background_enable,
    input wire lp_trigger_mode,
    input wire cal_trigger,
    input wire [2:0] offset_avg_sel,
    input wire [2:0] linearity_avg_sel,
    // Status
    output reg [2:0] state_code,
    output reg foreground_complete,
    output reg background_halted,
    output reg core_wake
);

localparam ST_IDLE = `CS_IDLE;
localparam ST_RESET = `CS_RESET;
localparam ST_FG = `CS_FG;
localparam ST_BG_RUN = `CS_BG_RUN;
localparam ST_BG_HALT = `CS_BG_HALT;
localparam ST_DONE = `CS_DONE;

reg [11:0] count;

// Deeper averaging doubles the time per step
function [11:0] avg_cycles;
    input [2:0] sel;
    begin
        avg_cycles = `AVG_BASE_CYCLES << sel;
    end
endfunction

always @(posedge aclk) begin
    if (!aresetn || !cal_enable) begin
        state_code <= ST_IDLE;
        count <= `COUNT_ZERO;
        foreground_complete <= 1'b0;
        background_halted <= 1'b0;
    end else begin
        case (state_code)
            ST_IDLE: begin
                state_code <= ST_RESET;
            end
            ST_RESET: begin
                // Values are cleared either way; foreground only if asked
                if (foreground_run_enable) begin
                    state_code <= ST_FG;
                    count <= avg_cycles(linearity_avg_sel);
                end else begin
                    foreground_complete <= 1'b1;
                    if (background_enable) begin
                        state_code <= ST_BG_RUN;
                        count <= avg_cycles(offset_avg_sel);
                    end else begin
                        state_code <= ST_DONE;
                        background_halted <= 1'b1;
                    end
                end
            end
            ST_FG: begin
                if (count == `COUNT_LAST) begin
                    foreground_complete <= 1'b1;
                    if (background_enable) begin
                        state_code <= ST_BG_RUN;
                        count <= avg_cycles(offset_avg_sel);
                    end else begin
                        state_code <= ST_DONE;
                        background_halted <= 1'b1;
                    end
                end else begin
                    count <= count - `COUNT_LAST;
                end
            end
            ST_BG_RUN: begin
                // Halt only at a phase boundary, never mid-average
                if (count == `COUNT_LAST) begin
                    count <= avg_cycles(offset_avg_sel);
                    if (!cal_trigger && !lp_trigger_mode) begin
                        state_code <= ST_BG_HALT;
                        background_halted <= 1'b1;
                    end
                end else begin
                    count <= count - `COUNT_LAST;
                end
            end
            ST_BG_HALT: begin
                if (cal_trigger || lp_trigger_mode) begin
                    state_code <= ST_BG_RUN;
                    background_halted <= 1'b0;
                    count <= avg_cycles(offset_avg_sel);
                end
            end
            ST_DONE: begin
                state_code <= ST_DONE;
            end
            default: begin
                state_code <= ST_IDLE;
            end
        endcase
    end
end

// Offline core sleeps on a high trigger in triggered low-power mode
always @(posedge aclk) begin
    if (!aresetn) begin
        core_wake <= 1'b1;
    end else if (lp_trigger_mode && state_code == ST_BG_RUN) begin
        core_wake <= !cal_trigger;
    end else begin
        core_wake <= 1'b1;
    end
end

endmodule // cal_sequencer

// file: cal_regs_asserts.sv
module cal_regs_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Pins and fields
    input wire logic cal_indicator_pin,
    input wire logic cal_trigger,
    input wire logic core_wake,
    input wire logic [2:0] offset_avg_sel,
    input wire logic [2:0] linearity_avg_sel
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_w_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_b_wait;
        bvalid && !bready;
    endsequence

    a_write_answer: assert property (s_w_taken |-> ##[1:2] bvalid)
        else $error("write answer missing");
    a_resp_hold: assert property (s_b_wait |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    a_read_hold: assert property (rvalid && !rready |=> $stable(rdata))
        else $error("read data changed while waiting");
    a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_avg_reset: assert property ($rose(aresetn) |->
        offset_avg_sel == 3'h6 && linearity_avg_sel == 3'h1)
        else $error("averaging fields wrong after reset");
    a_trig_reset: assert property ($rose(aresetn) |->
        cal_trigger && core_wake && !cal_indicator_pin)
        else $error("trigger outputs wrong after reset");
    a_avg_by_write: assert property (
        $changed({offset_avg_sel, linearity_avg_sel}) |-> $rose(bvalid))
        else $error("averaging field changed without a write");
endmodule // cal_regs_asserts

bind cal_ctrl_status_regs cal_regs_asserts u_chk (.*);

// file: cal_pin_host.sv
module cal_pin_host (
    // Clock
    input wire logic aclk,
    // Levels commanded by the bench
    input wire logic trig_req,
    input wire logic alarm_req,
    input wire logic [3:0] lag,
    // Pins into the device
    output logic cal_trigger_pin,
    output logic alarm_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt = 4'h0;

    // Trigger idles high so an unused trigger requests nothing
    initial cal_trigger_pin = 1'h1;
    initial alarm_flag = 1'h0;

    // A nonzero lag models slow external logic
    always @(posedge aclk) begin
        if (cal_trigger_pin == trig_req && alarm_flag == alarm_req) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag) begin
            cal_trigger_pin <= trig_req;
            alarm_flag <= alarm_req;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // cal_pin_host

// file: cal_ctrl_status_regs_test.sv
module cal_ctrl_status_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h1, lag = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, lp_wake_delay_sel;
    logic trig_req = 1'h1, alarm_req = 1'h0, cal_trigger_pin, alarm_flag;
    logic cal_indicator_pin, cal_trigger, core_wake;
    logic [2:0] offset_avg_sel, linearity_avg_sel, lp_sleep_delay_sel;
    int err_total = 0, comparisons = 0;

    cal_ctrl_status_regs u_dut (.*);
    cal_pin_host u_host (.*);

    always #25 aclk = ~aclk;

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic hang;
        err_total++;
        $display("mismatch bus answer expected 1 seen 0");
        final_report;
    endtask

    task automatic wr(input [7:0] idx, input [7:0] d, input [1:0] er);
        int n;
        n = 0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            n++;
        end while (bvalid !== 1'h1 && n < 100);
        if (bvalid !== 1'h1) hang;
        chk("bresp", {6'h00, bresp}, {6'h00, er});
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input [7:0] idx, output logic [7:0] d, input [1:0] er);
        int n;
        n = 0;
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            n++;
        end while (rvalid !== 1'h1 && n < 100);
        if (rvalid !== 1'h1) hang;
        d = rdata[7:0];
        chk("rresp", {6'h00, rresp}, {6'h00, er});
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rck(input [7:0] idx, input [7:0] e, input string nm);
        logic [7:0] d;
        rd(idx, d, 2'h0);
        chk(nm, d, e);
    endtask

    // Status moves on its own, so read it until it settles or gives up
    task automatic poll(input [7:0] e, input string nm);
        logic [7:0] d;
        int n;
        n = 0;
        do begin
            rd(8'h6a, d, 2'h0);
            n++;
        end while (d !== e && n < 100);
        chk(nm, d, e);
        // A status that never settles ends the run here
        if (d !== e) final_report;
    endtask

    task automatic t_reset;
        chk("avg ports", {2'h0, offset_avg_sel, linearity_avg_sel}, 8'h31);
        chk("trigger", {7'h00, cal_trigger}, 8'h01);
        chk("lp ports", {3'h0, lp_sleep_delay_sel, lp_wake_delay_sel},
            8'h11);
        rck(8'h62, 8'h03, "run control");
        rck(8'h68, 8'h61, "averaging");
        rck(8'h6b, 8'h00, "pin setup");
        rck(8'h6c, 8'h01, "sw trigger");
        rck(8'h6e, 8'h88, "lp timing");
        wr(8'h62, 8'h00, 2'h0);
        poll(8'h00, "idle status");
        $display("test reset done");
    endtask

    task automatic t_avg;
        logic [7:0] v [4] = '{8'h35, 8'h70, 8'h07, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(8'h68, v[i], 2'h0);
            rck(8'h68, v[i], "averaging");
            chk("avg ports", {2'h0, offset_avg_sel, linearity_avg_sel}, {2'h0, v[i][6:4], v[i][2:0]});
        end
        $display("test averaging done");
    endtask

    task automatic t_ro;
        logic [7:0] d;
        wr(8'h6a, 8'h1f, 2'h0);
        rck(8'h6a, 8'h00, "status");
        wr(8'h6f, 8'h01, 2'h2);
        rd(8'h6f, d, 2'h2);
        chk("unmapped", d, 8'h00);
        $display("test read only done");
    endtask

    task automatic t_fg;
        wr(8'h62, 8'h03, 2'h0);
        poll(8'h17, "fg run done");
        // Alarm held low so that each source gives its own level
        for (int s = 0; s < 4; s++) begin
            wr(8'h6b, {5'h00, s[1:0], 1'h0}, 2'h0);
            repeat (6) @(posedge aclk);
            chk("indicator", {7'h00, cal_indicator_pin},
                {7'h00, s < 2});
        end
        wr(8'h6b, 8'h04, 2'h0);
        alarm_req <= 1'h1;
        repeat (6) @(posedge aclk);
        chk("alarm high", {7'h00, cal_indicator_pin}, 8'h01);
        alarm_req <= 1'h0;
        repeat (6) @(posedge aclk);
        chk("alarm low", {7'h00, cal_indicator_pin}, 8'h00);
        wr(8'h62, 8'h00, 2'h0);
        poll(8'h00, "cleared");
        wr(8'h62, 8'h01, 2'h0);
        poll(8'h17, "fg skipped");
        wr(8'h6a, 8'h00, 2'h0);
        rck(8'h6a, 8'h17, "status kept");
        $display("test foreground done");
    endtask

    task automatic t_bg;
        lag <= 4'h3;
        wr(8'h6b, 8'h00, 2'h0);
        wr(8'h62, 8'h00, 2'h0);
        wr(8'h62, 8'h05, 2'h0);
        poll(8'h0d, "bg run");
        wr(8'h6b, 8'h02, 2'h0);
        repeat (2) @(posedge aclk);
        chk("run indicator", {7'h00, cal_indicator_pin}, 8'h00);
        wr(8'h6c, 8'h00, 2'h0);
        poll(8'h13, "bg halt");
        chk("halt indicator", {7'h00, cal_indicator_pin}, 8'h01);
        wr(8'h6c, 8'h01, 2'h0);
        poll(8'h0d, "bg resume");
        trig_req <= 1'h0;
        repeat (40) @(posedge aclk);
        chk("pin ignored", {7'h00, cal_trigger}, 8'h01);
        rck(8'h6a, 8'h0d, "still run");
        wr(8'h6b, 8'h01, 2'h0);
        poll(8'h13, "pin halt");
        chk("pin trigger", {7'h00, cal_trigger}, 8'h00);
        wr(8'h6c, 8'h00, 2'h0);
        trig_req <= 1'h1;
        poll(8'h0d, "pin resume");
        wr(8'h6e, 8'h8b, 2'h0);
        trig_req <= 1'h0;
        repeat (12) @(posedge aclk);
        chk("wake", {7'h00, core_wake}, 8'h01);
        trig_req <= 1'h1;
        repeat (12) @(posedge aclk);
        chk("sleep", {7'h00, core_wake}, 8'h00);
        wr(8'h6e, 8'h88, 2'h0);
        wr(8'h6b, 8'h00, 2'h0);
        wr(8'h6c, 8'h01, 2'h0);
        repeat (4) @(posedge aclk);
        chk("idle trigger", {7'h00, cal_trigger}, 8'h01);
        $display("test background done");
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_avg;
        t_ro;
        t_fg;
        t_bg;
        final_report;
    end
endmodule // cal_ctrl_status_regs_test
